// ---- tpwa_regs.vh ----
// register map, field positions, reset values and fixed profile settings of the word aligner
`ifndef TPWA_REGS_VH
`define TPWA_REGS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define TPWA_ADDR_CTRL      8'h00
`define TPWA_ADDR_SYNC      8'h04
`define TPWA_ADDR_RUNLEN    8'h08
`define TPWA_ADDR_PATTERN   8'h0c
`define TPWA_ADDR_STATUS    8'h10

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define TPWA_CTRL_BITREV    0
`define TPWA_CTRL_INFLIP    1
`define TPWA_CTRL_WIDTH10   2
`define TPWA_CTRL_GBE       3
`define TPWA_CTRL_SRIO      4
`define TPWA_CTRL_TXRST     5
`define TPWA_CTRL_RXRST     6
`define TPWA_CTRL_SLIP_LO   8
`define TPWA_CTRL_SLIP_HI   11
`define TPWA_CTRL_RESET     32'h0000_0004

// ---------------------------------------------------------------
// sync register: acquire count, lose count minus one, good run minus one
// ---------------------------------------------------------------
`define TPWA_SYNC_RESET     32'h00fe_0203
`define TPWA_SRIO_ACQUIRE   8'd127
`define TPWA_SRIO_LOSE_M1   6'd2
`define TPWA_SRIO_GOOD_M1   8'd254

// ---------------------------------------------------------------
// run length and pattern
// ---------------------------------------------------------------
`define TPWA_RUNLEN_RESET   5'h1f
`define TPWA_STEP_8B        8'd4
`define TPWA_STEP_10B       8'd5
`define TPWA_PATTERN_RESET  10'h0fa
`define TPWA_GBE_COMMAS     2'd3

`endif

// ---- tpwa_top.v ----
// transmit coding, word aligner and run length check behind apb
//
// Functional notes
// R1: bit reversal mirrors word at serializer input
// R2: input flip mirrors each byte before buffer
// R3: transmit bits delayed by programmed slip amount
// R4: serializer sends least significant bit first
// R5: serializer emits one bit per clock
// R6: lose count 1-64, good run 1-256
// R7: after receive reset, search pattern or complement
// R8: sync flag rises after programmed valid groups
// R9: sync drops after programmed errors without goods
// R10: after loss, reacquire programmed valid groups
// R11: run violation flag when run reaches threshold
// R12: run violation flag held two cycles minimum
// R13: threshold 4-128 step 4, 5-160 step 5
// R14: gigabit profile sends three commas after reset
// R15: sender keeps odd data count before sync; the transmit path keeps no data count
// R16: rapidio profile fixes 127, 3, 255
// R17: rapidio profile uses 10-bit pattern
// R18: run counter restarts when bit value changes
//
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tpwa_regs.vh"

// ---------------------------------------------------------------
// synchronous fifo
// ---------------------------------------------------------------
module tpwa_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rstN,
    input  wire             clkEn,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_q;
    reg [AW-1:0]    rdPtr_q;
    reg [AW:0]      count_q;
    reg             full_q;
    reg             empty_q;
    wire            push = inValid & ~full_q;
    wire            pop  = outReady & ~empty_q;
    wire [AW:0]     count_d = push & ~pop ? count_q + 1'b1 : (pop & ~push ? count_q - 1'b1 : count_q);

    assign inReady  = ~full_q;
    assign outValid = ~empty_q;
    assign outData  = mem[rdPtr_q];

    // storage has no reset, only pointers, count and flags do
    always @(posedge clk) begin
        if (clkEn && push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // pointers and registered full and empty flags
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            full_q  <= 1'b0;
            empty_q <= 1'b1;
        end else if (clkEn) begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count_q <= count_d;
            full_q  <= (count_d == DEPTH[AW:0]);
            empty_q <= (count_d == {(AW+1){1'b0}});
        end
    end
endmodule // tpwa_fifo

// ---------------------------------------------------------------
// top level
// ---------------------------------------------------------------
module tpwa_top (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        clkEn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [15:0] txData,
    input  wire        txValid,
    output reg         txReady,
    output reg         txSerial,
    input  wire        rxSerial,
    output reg         rxSyncStatus,
    output reg         rxRunViolation
);
    localparam LOSS = 1'b0;
    localparam SYNC = 1'b1;

    // mirror the low 8 or all 10 bits of a word
    function [9:0] mirror;
        input [9:0] d;
        input       w10;
        integer     i;
        begin
            mirror = 10'h000;
            for (i = 0; i < 10; i = i + 1) begin
                if (w10) begin
                    mirror[i] = d[9-i];
                end else if (i < 8) begin
                    mirror[i] = d[7-i];
                end
            end
        end
    endfunction

    // mirror inside each byte of a 16-bit word
    function [15:0] flipBytes;
        input [15:0] d;
        integer      i;
        begin
            flipBytes = 16'h0000;
            for (i = 0; i < 8; i = i + 1) begin
                flipBytes[i]   = d[7-i];
                flipBytes[i+8] = d[15-i];
            end
        end
    endfunction

    // ones in a code group, for the error test
    function [3:0] ones;
        input [9:0] d;
        integer     i;
        begin
            ones = 4'h0;
            for (i = 0; i < 10; i = i + 1) begin
                ones = ones + {3'b000, d[i]};
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // reset release and receive pin synchroniser
    // ---------------------------------------------------------------
    reg rstMeta_q;
    reg rstN_q;
    reg rxMeta_q;
    reg rxBit_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_q <= 1'b0;
            rstN_q    <= 1'b0;
        end else if (clkEn) begin
            rstMeta_q <= 1'b1;
            rstN_q    <= rstMeta_q;
        end
    end

    always @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            rxMeta_q <= 1'b0;
            rxBit_q  <= 1'b0;
        end else if (clkEn) begin
            rxMeta_q <= rxSerial;
            rxBit_q  <= rxMeta_q;
        end
    end

    // ---------------------------------------------------------------
    // apb register file
    // ---------------------------------------------------------------
    reg  [31:0] ctrl_q;
    reg  [31:0] syncCfg_q;
    reg  [4:0]  runStep_q;
    reg  [9:0]  pattern_q;
    reg         state_q;
    reg  [6:0]  errCnt_q;
    wire        fifoFull;
    wire        fifoEmpty;
    wire        setup  = psel & ~penable & ~pready;
    wire        wrEn   = psel & penable & pready & pwrite;
    wire        mapped = (paddr == `TPWA_ADDR_CTRL) | (paddr == `TPWA_ADDR_SYNC) | (paddr == `TPWA_ADDR_RUNLEN) |
                         (paddr == `TPWA_ADDR_PATTERN) | (paddr == `TPWA_ADDR_STATUS);
    reg  [31:0] rdMux;

    always @* begin
        case (paddr)
            `TPWA_ADDR_CTRL:    rdMux = ctrl_q;
            `TPWA_ADDR_SYNC:    rdMux = syncCfg_q;
            `TPWA_ADDR_RUNLEN:  rdMux = {27'h0000000, runStep_q};
            `TPWA_ADDR_PATTERN: rdMux = {22'h000000, pattern_q};
            `TPWA_ADDR_STATUS:  rdMux = {18'h00000, 1'b0, errCnt_q, 2'b00, fifoFull, fifoEmpty,
                                         rxRunViolation, state_q};
            default:            rdMux = 32'h0000_0000;
        endcase
    end

    // no wait cycle: answer registered during setup, write lands at the access edge
    always @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
            ctrl_q    <= `TPWA_CTRL_RESET;
            syncCfg_q <= `TPWA_SYNC_RESET;
            runStep_q <= `TPWA_RUNLEN_RESET;
            pattern_q <= `TPWA_PATTERN_RESET;
        end else if (clkEn) begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= setup & ~pwrite ? rdMux : 32'h0000_0000;
            if (wrEn && paddr == `TPWA_ADDR_CTRL) begin
                ctrl_q <= {20'h00000, pwdata[11:8], 1'b0, pwdata[6:0]};
            end
            if (wrEn && paddr == `TPWA_ADDR_SYNC) begin
                syncCfg_q <= {8'h00, pwdata[23:16], 2'b00, pwdata[13:8], pwdata[7:0]}; // R6
            end
            if (wrEn && paddr == `TPWA_ADDR_RUNLEN) begin
                runStep_q <= pwdata[4:0]; // R13
            end
            if (wrEn && paddr == `TPWA_ADDR_PATTERN) begin
                pattern_q <= pwdata[9:0];
            end
        end
    end

    // profile overrides: the rapidio lane forces its own counts and 10-bit groups
    wire       srio    = ctrl_q[`TPWA_CTRL_SRIO];
    wire       w10     = ctrl_q[`TPWA_CTRL_WIDTH10] | srio;             // R17
    wire [7:0] acqNeed = srio ? `TPWA_SRIO_ACQUIRE : syncCfg_q[7:0];   // R16
    wire [5:0] loseM1  = srio ? `TPWA_SRIO_LOSE_M1 : syncCfg_q[13:8];  // R16
    wire [7:0] goodM1  = srio ? `TPWA_SRIO_GOOD_M1 : syncCfg_q[23:16]; // R16
    wire       txRst   = ctrl_q[`TPWA_CTRL_TXRST];
    wire       rxRst   = ctrl_q[`TPWA_CTRL_RXRST];

    // ---------------------------------------------------------------
    // transmit path
    // ---------------------------------------------------------------
    wire [15:0] fifoOut;
    wire        fifoValid;
    wire        fifoInReady;
    reg         txPop;
    wire [15:0] txIn = ctrl_q[`TPWA_CTRL_INFLIP] ? flipBytes(txData) : txData; // R2

    assign fifoFull  = ~fifoInReady;
    assign fifoEmpty = ~fifoValid;

    tpwa_fifo #(
        .WIDTH (16),
        .DEPTH (16),
        .AW    (4)
    ) txFifo (
        .clk      (clk),
        .rstN     (rstN_q),
        .clkEn    (clkEn),
        .inData   (txIn),
        .inValid  (txValid),
        .inReady  (fifoInReady),
        .outData  (fifoOut),
        .outValid (fifoValid),
        .outReady (txPop)
    );

    reg  [9:0]  txShift_q;
    reg  [3:0]  txPos_q;
    reg  [1:0]  commaLeft_q;
    reg  [15:0] txHist_q;
    wire        txLast  = txPos_q == (w10 ? 4'd9 : 4'd7);
    wire [15:0] txHist_d = {txHist_q[14:0], txShift_q[0]};
    reg  [9:0]  txWord;

    // word chosen at each group boundary: commas first, then data, idle pattern when starved
    always @* begin
        txPop  = 1'b0;
        txWord = pattern_q;
        if (txLast && !txRst) begin
            if (ctrl_q[`TPWA_CTRL_GBE] && commaLeft_q != 2'd0) begin
                txWord = pattern_q; // R14
            end else if (fifoValid) begin
                txWord = fifoOut[9:0];
                txPop  = 1'b1;
            end
        end
    end

    // serializer: one bit a clock, bit 0 first, idle stream is the pattern
    always @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            txShift_q   <= 10'h000;
            txPos_q     <= 4'd9;
            commaLeft_q <= `TPWA_GBE_COMMAS;
            txHist_q    <= 16'h0000;
            txSerial    <= 1'b0;
            txReady     <= 1'b0;
        end else if (clkEn) begin
            txReady <= fifoInReady;
            if (txRst) begin
                txShift_q   <= 10'h000;
                txPos_q     <= 4'd9;
                commaLeft_q <= `TPWA_GBE_COMMAS; // R14
            end else if (txLast) begin
                txShift_q <= ctrl_q[`TPWA_CTRL_BITREV] ? mirror(txWord, w10) : txWord; // R1
                txPos_q   <= 4'd0;
                if (ctrl_q[`TPWA_CTRL_GBE] && commaLeft_q != 2'd0) begin
                    commaLeft_q <= commaLeft_q - 2'd1; // R14
                end
            end else begin
                txShift_q <= {1'b0, txShift_q[9:1]}; // R4 R5
                txPos_q   <= txPos_q + 4'd1;
            end
            txHist_q <= txHist_d;
            txSerial <= txHist_d[ctrl_q[`TPWA_CTRL_SLIP_HI:`TPWA_CTRL_SLIP_LO]]; // R3
        end
    end

    // ---------------------------------------------------------------
    // word aligner and synchronisation machine
    // ---------------------------------------------------------------
    reg  [9:0] rxHist_q;
    reg  [3:0] rxPos_q;
    reg  [7:0] acqCnt_q;
    reg  [7:0] goodCnt_q;
    wire [7:0] acqNext  = (rxPos_q == (w10 ? 4'd9 : 4'd7)) ? acqCnt_q + 8'd1 : 8'd1;
    wire       boundary = rxPos_q == (w10 ? 4'd9 : 4'd7);
    wire [9:0] group    = w10 ? rxHist_q : {2'b00, rxHist_q[9:2]};
    wire       match    = w10 ? (rxHist_q == pattern_q || rxHist_q == ~pattern_q) :
                          (group[7:0] == pattern_q[7:0] || group[7:0] == ~pattern_q[7:0]);
    wire [3:0] weight   = ones(group);
    wire       badGroup = w10 ? (weight < 4'd4 || weight > 4'd6) : (group[7:0] == 8'h00 || group[7:0] == 8'hff);

    // newest bit enters at the top so a full window holds the first bit in bit 0
    always @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            rxHist_q     <= 10'h000;
            rxPos_q      <= 4'd0;
            state_q      <= LOSS;
            acqCnt_q     <= 8'd0;
            errCnt_q     <= 7'd0;
            goodCnt_q    <= 8'd0;
            rxSyncStatus <= 1'b0;
        end else if (clkEn) begin
            rxHist_q <= {rxBit_q, rxHist_q[9:1]};
            if (rxRst) begin
                rxPos_q   <= 4'd0;
                state_q   <= LOSS; // R7
                acqCnt_q  <= 8'd0;
                errCnt_q  <= 7'd0;
                goodCnt_q <= 8'd0;
            end else if (state_q == LOSS) begin
                rxPos_q <= boundary ? 4'd0 : rxPos_q + 4'd1;
                if (match) begin
                    rxPos_q  <= 4'd0; // R7
                    acqCnt_q <= acqNext;
                    if (acqNext >= acqNeed) begin
                        state_q   <= SYNC; // R8 R10
                        errCnt_q  <= 7'd0;
                        goodCnt_q <= 8'd0;
                    end
                end else if (boundary) begin
                    acqCnt_q <= 8'd0;
                end
            end else begin
                rxPos_q <= boundary ? 4'd0 : rxPos_q + 4'd1;
                if (boundary && badGroup) begin
                    goodCnt_q <= 8'd0;
                    if (errCnt_q == {1'b0, loseM1}) begin
                        state_q  <= LOSS; // R9
                        acqCnt_q <= 8'd0;
                        errCnt_q <= 7'd0;
                    end else begin
                        errCnt_q <= errCnt_q + 7'd1;
                    end
                end else if (boundary) begin
                    if (goodCnt_q == goodM1) begin
                        goodCnt_q <= 8'd0; // R6
                        if (errCnt_q != 7'd0) begin
                            errCnt_q <= errCnt_q - 7'd1;
                        end
                    end else begin
                        goodCnt_q <= goodCnt_q + 8'd1;
                    end
                end
            end
            rxSyncStatus <= state_q == SYNC && !rxRst;
        end
    end

    // ---------------------------------------------------------------
    // run length violation
    // ---------------------------------------------------------------
    reg  [7:0] runCnt_q;
    reg        runHold_q;
    wire [7:0] unitStep = w10 ? `TPWA_STEP_10B : `TPWA_STEP_8B;
    wire [7:0] stepNum  = {3'b000, runStep_q} + 8'd1;
    wire [7:0] thresh   = stepNum * unitStep; // R13
    wire [7:0] runNext  = (rxBit_q != rxHist_q[9]) ? 8'd1 : (runCnt_q == 8'hff ? runCnt_q : runCnt_q + 8'd1);
    wire       runHit   = runNext == thresh && runCnt_q != thresh;

    // pulse stretched so a slower sampler cannot miss it
    always @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            runCnt_q       <= 8'd0;
            runHold_q      <= 1'b0;
            rxRunViolation <= 1'b0;
        end else if (clkEn) begin
            runCnt_q <= runNext; // R18
            if (runHit) begin
                rxRunViolation <= 1'b1; // R11
                runHold_q      <= 1'b1; // R12
            end else begin
                rxRunViolation <= runHold_q; // R12
                runHold_q      <= 1'b0;
            end
        end
    end
endmodule // tpwa_top
`default_nettype wire

// ---- tpwa_props.sv ----
// concurrent checks on the word aligner top ports
`timescale 1ns/10ps
`default_nettype none
module tpwa_props (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        clkEn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] txData,
    input wire logic        txValid,
    input wire logic        txReady,
    input wire logic        txSerial,
    input wire logic        rxSerial,
    input wire logic        rxSyncStatus,
    input wire logic        rxRunViolation
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // apb answer: one wait-free access cycle, error only off the map
    // ------------------------------------------------------------
    ready_after_setup_a: assert property (psel && !penable && clkEn |=> pready)
        else $error("pready missing after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    unmapped_err_a: assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
        else $error("pslverr does not follow the address map");
    rdata_quiet_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("prdata not zero outside a read");

    // ------------------------------------------------------------
    // freeze and receive flags
    // ------------------------------------------------------------
    // a low enable must hold every output, else the fabric sees half-steps
    freeze_hold_a: assert property (!clkEn |=> $stable(txSerial) && $stable(txReady)
        && $stable(rxSyncStatus) && $stable(rxRunViolation))
        else $error("state moved while clock enable low");
    rlv_two_cycles_a: assert property ($rose(rxRunViolation) |=> rxRunViolation)
        else $error("run violation shorter than two cycles");
    reacquire_wait_a: assert property ($fell(rxSyncStatus) |=> !rxSyncStatus [*8])
        else $error("sync back before a full group");
    toggling_no_rlv_a: assert property (($changed(rxSerial)) [*8] |=> !$rose(rxRunViolation))
        else $error("run violation on a toggling line");
endmodule // tpwa_props

bind tpwa_top tpwa_props tpwa_props_i (.*);
`default_nettype wire

// ---- tpwa_link_partner.sv ----
// remote serial partner: sends 10-bit groups and watches the transmit line
`timescale 1ns/10ps
`default_nettype none
module tpwa_link_partner (
    input  wire logic       clk,
    input  wire logic       txSerial,
    output var  logic       rxSerial,
    output var  logic [9:0] seen
);
    localparam logic [9:0] IDLE = 10'h155;
    logic [9:0] q[$];
    logic [9:0] cur;
    int         idx;

    initial begin
        cur = IDLE;
        idx = 0;
        rxSerial = 1'b0;
        seen = 10'h000;
    end

    // ------------------------------------------------------------
    // back to back groups lsb first; idle sends alternating bits
    // ------------------------------------------------------------
    always @(posedge clk) begin
        seen <= {txSerial, seen[9:1]};
        rxSerial <= cur[idx];
        if (idx == 9) begin
            idx <= 0;
            cur <= (q.size() != 0) ? q.pop_front() : IDLE;
        end else begin
            idx <= idx + 1;
        end
    end

    // returns at the edge driving the last bit when last is set
    task automatic send(input logic [9:0] w, input int n, input bit last);
        repeat (n) q.push_back(w);
        if (last) begin
            while (q.size() != 0) @(posedge clk);
            @(posedge clk iff idx == 9);
        end
    endtask
endmodule // tpwa_link_partner
`default_nettype wire

// ---- test_transceiver_pcs_word_aligner.sv ----
// self-checking bench for the word aligner top
`timescale 1ns/10ps
`default_nettype none
`include "tpwa_regs.vh"
module test_transceiver_pcs_word_aligner;
    logic        clk, reset_n, clkEn, psel, penable, pwrite, txValid, err;
    logic        pready, pslverr, txReady, txSerial, rxSerial, rxSyncStatus, rxRunViolation;
    logic [7:0]  paddr;
    logic [15:0] txData;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  seen;
    int          mismatches, samples_checked, cycles, lat;

    tpwa_top tpwa_top_i (.*);
    tpwa_link_partner tpwa_link_partner_i (.*);

    // ------------------------------------------------------------
    // clock, hang guard, helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // run takes a few thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    // setup, access until pready, release, one idle edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(name, exp, rd);
    endtask
    function automatic logic probe(input int sel);
        return sel == 0 ? rxSyncStatus : sel == 1 ? rxRunViolation : txReady;
    endfunction
    task automatic waitBit(input string name, input int sel, input logic want, input int lim);
        for (int n = 0; n < lim && probe(sel) !== want; n++) @(posedge clk);
        check(name, {31'h0, want}, {31'h0, probe(sel)});
    endtask
    task automatic holdBit(input string name, input int sel, input logic want, input int n);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(posedge clk);
            ok &= (probe(sel) === want);
        end
        check(name, 32'h1, {31'h0, ok});
    endtask
    task automatic waitSeen(input string name, input logic [9:0] exp, input logic [9:0] mask);
        for (lat = 0; lat < 80 && (seen & mask) !== exp; lat++) @(posedge clk);
        check(name, {22'h0, exp}, {22'h0, seen & mask});
    endtask
    task automatic push(input logic [15:0] d);
        txData <= d;
        txValid <= 1'b1;
        do @(posedge clk); while (txReady !== 1'b1);
        txValid <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        clkEn = 1'b1;
        {psel, penable, pwrite, txValid} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        txData = 16'h0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdchk("ctrl", `TPWA_ADDR_CTRL, `TPWA_CTRL_RESET);
        rdchk("sync", `TPWA_ADDR_SYNC, `TPWA_SYNC_RESET);
        rdchk("runlen", `TPWA_ADDR_RUNLEN, `TPWA_RUNLEN_RESET);
        rdchk("pattern", `TPWA_ADDR_PATTERN, {22'h0, `TPWA_PATTERN_RESET});
        rdchk("unmapped", 8'h14, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        apb(`TPWA_ADDR_SYNC, 1'b1, 32'h0000_0104); // acquire 4, lose 2, good run 1
        rdchk("sync rw", `TPWA_ADDR_SYNC, 32'h0000_0104);
        clkEn <= 1'b0;
        repeat (10) @(posedge clk);
        clkEn <= 1'b1;
        // transmit order, reversal, byte flip, then fill and drain
        waitSeen("idle pattern", `TPWA_PATTERN_RESET, 10'h3ff);
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'h0000_0005);
        waitSeen("reversed", 10'h17c, 10'h3ff);
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'h0000_0002);
        push(16'hbcad);
        waitSeen("flipped byte", {8'hb5, 2'h0}, 10'h3fc);
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'h22);
        txData <= 16'h00ad;
        txValid <= 1'b1;
        waitBit("fifo refuses", 2, 1'b0, 40);
        apb(`TPWA_ADDR_STATUS, 1'b0, 32'h0);
        check("fifo full", 32'h8, rd & 32'hc);
        txValid <= 1'b0;
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'h2);
        repeat (200) @(posedge clk);
        apb(`TPWA_ADDR_STATUS, 1'b0, 32'h0);
        check("fifo empty", 32'h4, rd & 32'hc);
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'h2c);
        push(16'h03c3);
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'hc);
        waitSeen("data after commas", 10'h3c3, 10'h3ff);
        check("comma lead", 32'h1, {31'h0, lat > 30 && lat < 50});
        // acquire, hold, lose, reacquire on the complement
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'h0000_0044);
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'h0000_0004);
        check("searching", 32'h0, {31'h0, rxSyncStatus});
        tpwa_link_partner_i.send(`TPWA_PATTERN_RESET, 4, 1'b1);
        check("no sync at three", 32'h0, {31'h0, rxSyncStatus});
        waitBit("sync acquired", 0, 1'b1, 20);
        tpwa_link_partner_i.send(10'h000, 1, 1'b0);
        tpwa_link_partner_i.send(`TPWA_PATTERN_RESET, 1, 1'b0);
        tpwa_link_partner_i.send(10'h000, 2, 1'b1);
        check("sync held", 32'h1, {31'h0, rxSyncStatus});
        waitBit("sync lost", 0, 1'b0, 20);
        tpwa_link_partner_i.send(10'h305, 4, 1'b1);
        check("still lost", 32'h0, {31'h0, rxSyncStatus});
        waitBit("sync regained", 0, 1'b1, 20);
        // rapidio profile overrides the sync register and forces 10-bit
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'h0000_0050);
        apb(`TPWA_ADDR_CTRL, 1'b1, 32'h0000_0010);
        tpwa_link_partner_i.send(`TPWA_PATTERN_RESET, 127, 1'b1);
        check("rapidio early", 32'h0, {31'h0, rxSyncStatus});
        waitBit("rapidio sync", 0, 1'b1, 20);
        // smallest threshold: one bit under passes, exact count flags
        for (int m = 0; m < 2; m++) begin
            apb(`TPWA_ADDR_CTRL, 1'b1, m ? 32'h4 : 32'h0);
            apb(`TPWA_ADDR_RUNLEN, 1'b1, 32'h0);
            waitBit("violation clear", 1, 1'b0, 40);
            tpwa_link_partner_i.send(m ? 10'h1e1 : 10'h1c7, 1, 1'b0);
            holdBit("short run", 1, 1'b0, 25);
            tpwa_link_partner_i.send(m ? 10'h1df : 10'h1cf, 1, 1'b0);
            waitBit("run violation", 1, 1'b1, 30);
        end
        summarize();
    end
endmodule // test_transceiver_pcs_word_aligner
`default_nettype wire
